// [rtl/pll_clock_ctrl.sv]
`timescale 1ns/100ps
`include "pll_ctl_defines.svh"
module pll_clock_ctrl
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sampled source clocks
  input wire logic CRYSTAL_CLOCK,
  input wire logic VCO_CLOCK,
  // Lock detector tolerance reports
  input wire logic IN_TRACK_TOL,
  input wire logic OUT_UNTRACK_TOL,
  input wire logic IN_LOCK_TOL,
  input wire logic OUT_UNLOCK_TOL,
  // Loop controls
  output logic LOOP_ENABLE,
  output logic FILTER_TRACKING,
  output logic [3:0] VCO_RANGE_FACTOR,
  output logic [3:0] FEEDBACK_DIVISOR,
  output logic FEEDBACK_PULSE,
  // Base clock
  output logic BASE_CLOCK_OUT,
  output logic BASE_SEL_VCO,
  // Lock change request
  output logic LOOP_IRQ
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  function automatic nibble_type n_decode(input nibble_type mul);
    n_decode = (mul == 4'h0) ? 4'h1 : mul;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic ie_r, ie_nxt, flag_r, flag_nxt, on_r, on_nxt, base_source_select_r, base_source_select_nxt;
  logic auto_r, auto_nxt, acq_r, acq_nxt, lock_r, lock_nxt;
  logic [7:0] mult_r, mult_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic hit_ctrl, hit_bw, hit_mult, mapped;
  logic wr_en, rd_setup, wr_ctrl, wr_bw, wr_mult, rd_ctrl, toggle;
  logic l_nonzero;

  src_switch_if sw ();

  assign hit_ctrl = reg_hit(PADDR, `LOOP_CTRL_IDX);
  assign hit_bw = reg_hit(PADDR, `BANDWIDTH_IDX);
  assign hit_mult = reg_hit(PADDR, `MULT_PROG_IDX);
  assign mapped = hit_ctrl | hit_bw | hit_mult;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_bw = wr_en & hit_bw;
  assign wr_mult = wr_en & hit_mult;
  assign rd_ctrl = rd_setup & hit_ctrl;
  assign l_nonzero = (mult_r[3:0] != 4'h0);

  // ---------------------------------------------------------------
  // APB handshake, no wait states; read data is latched in the setup cycle so it comes from a flop
  // ---------------------------------------------------------------
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = prdata_r;

  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_setup) begin
      prdata_nxt = 32'h0000_0000;
      if (hit_ctrl) begin
        prdata_nxt[`CTRL_IE_BIT] = ie_r & auto_r;
        prdata_nxt[`CTRL_FLAG_BIT] = flag_r & auto_r;
        prdata_nxt[`CTRL_ON_BIT] = on_r;
        prdata_nxt[`CTRL_SRC_SEL_BIT] = base_source_select_r;
        prdata_nxt[3:0] = `CTRL_LOW_READ;
      end else if (hit_bw) begin
        prdata_nxt[`BW_AUTO_BIT] = auto_r;
        prdata_nxt[`BW_LOCK_BIT] = lock_r & auto_r;
        prdata_nxt[`BW_ACQ_BIT] = acq_r;
      end else if (hit_mult) begin
        prdata_nxt[7:0] = mult_r;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Control, bandwidth and multiplier registers
  // ---------------------------------------------------------------
  always_comb begin
    ie_nxt = ie_r;
    on_nxt = on_r;
    base_source_select_nxt = base_source_select_r;
    auto_nxt = auto_r;
    acq_nxt = acq_r;
    lock_nxt = lock_r;
    mult_nxt = mult_r;
    flag_nxt = flag_r;
    if (wr_mult) begin
      mult_nxt = PWDATA[7:0]; // RL12 RL13
    end
    if (wr_bw) begin
      auto_nxt = PWDATA[`BW_AUTO_BIT];
    end
    if (auto_r) begin
      // Detector reports win; software writes are ignored here
      if (IN_TRACK_TOL) begin
        acq_nxt = 1'b1; // RL3 RL4
      end else if (OUT_UNTRACK_TOL) begin
        acq_nxt = 1'b0; // RL4
      end
      if (IN_LOCK_TOL) begin
        lock_nxt = 1'b1; // RL5
      end else if (OUT_UNLOCK_TOL) begin
        lock_nxt = 1'b0; // RL5
      end
    end else begin
      lock_nxt = 1'b0; // RL11
      if (wr_bw) begin
        acq_nxt = PWDATA[`BW_ACQ_BIT]; // RL7
      end
    end
    if (wr_ctrl) begin
      if (auto_r) begin
        ie_nxt = PWDATA[`CTRL_IE_BIT];
      end
      // Old values gate both, so loop and select need two writes
      on_nxt = PWDATA[`CTRL_ON_BIT] | base_source_select_r; // RL19 RL20
      // A select also needs the loop to stay on through the same write
      base_source_select_nxt = PWDATA[`CTRL_SRC_SEL_BIT] & on_r & on_nxt; // RL18 RL20
    end
    if (mult_nxt[3:0] == 4'h0) begin
      base_source_select_nxt = 1'b0; // RL15
    end
    toggle = auto_r & (lock_nxt != lock_r);
    // A toggle in the clearing cycle keeps the flag set
    if (!auto_r) begin
      flag_nxt = 1'b0; // RL11
    end else if (toggle) begin
      flag_nxt = 1'b1; // RL22
    end else if (rd_ctrl) begin
      flag_nxt = 1'b0; // RL22
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ie_r <= 1'b0;
      flag_r <= 1'b0;
      on_r <= `CTRL_ON_RST;
      base_source_select_r <= 1'b0;
      auto_r <= 1'b0;
      acq_r <= 1'b0;
      lock_r <= 1'b0;
      mult_r <= `MULT_PROG_RST;
    end else begin
      ie_r <= ie_nxt;
      flag_r <= flag_nxt;
      on_r <= on_nxt;
      base_source_select_r <= base_source_select_nxt;
      auto_r <= auto_nxt;
      acq_r <= acq_nxt;
      lock_r <= lock_nxt;
      mult_r <= mult_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs toward the analog loop
  // ---------------------------------------------------------------
  assign FILTER_TRACKING = acq_r; // RL1 RL2
  assign LOOP_ENABLE = on_r & l_nonzero; // RL15
  assign VCO_RANGE_FACTOR = mult_r[3:0]; // RL13
  assign FEEDBACK_DIVISOR = n_decode(mult_r[7:4]); // RL14
  assign LOOP_IRQ = auto_r & ie_r & flag_r; // RL6 RL11
  assign sw.want_vco = base_source_select_r & on_r & l_nonzero; // RL15 RL21
  assign BASE_SEL_VCO = sw.on_vco; // RL21

  fb_divider u_fb_divider (
    .clk(REF_CLK),
    .rst(RESET),
    .enable(LOOP_ENABLE),
    .vco_in(VCO_CLOCK),
    .divisor(FEEDBACK_DIVISOR),
    .fb_pulse(FEEDBACK_PULSE)
  );

  src_clock_switch u_src_clock_switch (
    .clk(REF_CLK),
    .rst(RESET),
    .xtal_in(CRYSTAL_CLOCK),
    .vco_in(VCO_CLOCK),
    .sel(sw.sw),
    .base_out(BASE_CLOCK_OUT)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  property p_acq_mode;
    !acq_r |-> !FILTER_TRACKING;
  endproperty
  a_acq_mode: assert property (p_acq_mode) else $error("tracking while bit clear"); // RL1

  property p_track_mode;
    acq_r |-> FILTER_TRACKING;
  endproperty
  a_track_mode: assert property (p_track_mode) else $error("not tracking while bit set"); // RL2

  property p_auto_track;
    auto_r && IN_TRACK_TOL |=> acq_r;
  endproperty
  a_auto_track: assert property (p_auto_track) else $error("auto tracking missed"); // RL3

  property p_acq_readonly;
    auto_r && wr_bw && !IN_TRACK_TOL && !OUT_UNTRACK_TOL |=> $stable(acq_r);
  endproperty
  a_acq_readonly: assert property (p_acq_readonly) else $error("auto acq written"); // RL4

  property p_lock_follow;
    auto_r && OUT_UNLOCK_TOL && !IN_LOCK_TOL |=> !lock_r;
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("unlock missed"); // RL5

  property p_irq_on_toggle;
    auto_r && ie_r && toggle && !wr_bw && !wr_ctrl |=> LOOP_IRQ;
  endproperty
  a_irq_on_toggle: assert property (p_irq_on_toggle) else $error("no irq on toggle"); // RL6

  property p_manual_acq;
    !auto_r && wr_bw && !PWDATA[`BW_ACQ_BIT] |=> !acq_r;
  endproperty
  a_manual_acq: assert property (p_manual_acq) else $error("manual acq not written"); // RL7

  property p_manual_quiet;
    !auto_r |=> !LOOP_IRQ && !lock_r;
  endproperty
  a_manual_quiet: assert property (p_manual_quiet) else $error("manual irq or lock"); // RL11

  property p_n_zero;
    mult_r[7:4] == 4'h0 |-> FEEDBACK_DIVISOR == 4'h1;
  endproperty
  a_n_zero: assert property (p_n_zero) else $error("zero multiplier not one"); // RL14

  property p_l_zero;
    mult_r[3:0] == 4'h0 |-> !LOOP_ENABLE && !sw.want_vco && !base_source_select_r;
  endproperty
  a_l_zero: assert property (p_l_zero) else $error("zero range not forced"); // RL15

  property p_sel_needs_on;
    $rose(base_source_select_r) |-> $past(on_r);
  endproperty
  a_sel_needs_on: assert property (p_sel_needs_on) else $error("vco picked while off"); // RL18

  property p_on_held;
    base_source_select_r && wr_ctrl |=> on_r;
  endproperty
  a_on_held: assert property (p_on_held) else $error("loop off while vco used"); // RL19

  property p_read_clears;
    rd_ctrl && !toggle ##1 !toggle |-> !flag_r;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag not cleared"); // RL22

  property p_busy_frozen;
    sw.busy |=> $stable(BASE_CLOCK_OUT);
  endproperty
  a_busy_frozen: assert property (p_busy_frozen) else $error("output moved while busy"); // RL16

  property p_ie_manual;
    !auto_r && wr_ctrl |=> $stable(ie_r);
  endproperty
  a_ie_manual: assert property (p_ie_manual) else $error("manual ie written"); // RL11

  property p_acq_untrack;
    auto_r && OUT_UNTRACK_TOL && !IN_TRACK_TOL |=> !acq_r;
  endproperty
  a_acq_untrack: assert property (p_acq_untrack) else $error("untrack missed"); // RL4

  property p_lock_in;
    auto_r && IN_LOCK_TOL |=> lock_r;
  endproperty
  a_lock_in: assert property (p_lock_in) else $error("lock missed"); // RL5

  property p_flag_set;
    toggle |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RL22

  property p_flag_manual;
    !auto_r |=> !flag_r;
  endproperty
  a_flag_manual: assert property (p_flag_manual) else $error("manual flag set"); // RL11

  property p_off_no_sel;
    !on_r && wr_ctrl |=> !base_source_select_r;
  endproperty
  a_off_no_sel: assert property (p_off_no_sel) else $error("select while off"); // RL18 RL20

  property p_sel_with_on;
    base_source_select_r |-> on_r;
  endproperty
  a_sel_with_on: assert property (p_sel_with_on) else $error("select without loop"); // RL19 RL20

  property p_want_gated;
    sw.want_vco |-> base_source_select_r && LOOP_ENABLE;
  endproperty
  a_want_gated: assert property (p_want_gated) else $error("vco wanted while off"); // RL15 RL21

  property p_n_pass;
    mult_r[7:4] != 4'h0 |-> FEEDBACK_DIVISOR == mult_r[7:4];
  endproperty
  a_n_pass: assert property (p_n_pass) else $error("divisor not n"); // RL12

  property p_irq_level;
    auto_r && ie_r && flag_r |-> LOOP_IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised"); // RL6

  property p_apb_answer;
    PSEL && PENABLE |-> PREADY && (PSLVERR == !mapped);
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bad bus answer");

  c_manual_track: cover property (!auto_r && wr_bw ##1 FILTER_TRACKING);
  c_lock_irq: cover property (auto_r && ie_r && toggle ##1 LOOP_IRQ);
  c_to_vco: cover property ($rose(BASE_SEL_VCO));
  c_flag_read: cover property (flag_r && rd_ctrl ##1 !flag_r);
endmodule

// [rtl/pll_ctl_defines.svh]
`ifndef PLL_CTL_DEFINES_SVH
`define PLL_CTL_DEFINES_SVH
// Contract
// RL1: Filter-mode bit clear means acquisition mode
// RL2: Otherwise the filter runs in tracking mode
// RL3: Auto mode: lock detector picks filter mode
// RL4: Auto mode: filter-mode bit read-only, detector driven
// RL5: Auto mode: lock indicator read-only, detector driven
// RL6: Lock toggle raises interrupt when enabled
// RL7: Manual mode: filter-mode bit written by software
// RL8: Software clears filter-mode before loop on
// RL9: Software waits acquisition time before tracking
// RL10: Software waits settle time before VCO select
// RL11: Manual mode: no lock indicator, no interrupts
// RL12: Upper nibble is feedback divisor N
// RL13: Lower nibble is VCO range factor L
// RL14: Multiplier zero behaves as one
// RL15: Range factor zero disables loop, forces crystal
// RL16: Source change holds output three plus three edges
// RL17: Switch output divided by two
// RL18: VCO select refused while loop off
// RL19: Loop off refused while VCO selected
// RL20: Loop and select changes need separate writes
// RL21: Select one routes VCO, zero routes crystal
// RL22: Control register read clears lock-change flag

// ---------------------------------------------------------------
// Register indices, byte address is four times the index
// ---------------------------------------------------------------
`define LOOP_CTRL_IDX 6'h1c
`define BANDWIDTH_IDX 6'h1d
`define MULT_PROG_IDX 6'h1e

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_IE_BIT 7
`define CTRL_FLAG_BIT 6
`define CTRL_ON_BIT 5
`define CTRL_SRC_SEL_BIT 4
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_ACQ_BIT 5

// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define CTRL_ON_RST 1'b1
`define CTRL_LOW_READ 4'hf
`define MULT_PROG_RST 8'h66
`define SWITCH_WAIT_EDGES 2'h3
`endif

// [rtl/pll_ctl_pkg.sv]
package pll_ctl_pkg;
  typedef enum logic [1:0] {SW_RUN, SW_HOLD_OLD, SW_HOLD_NEW} sw_state_type;
  typedef logic [3:0] nibble_type;
endpackage

// [rtl/src_switch_if.sv]
`timescale 1ns/100ps
interface src_switch_if;
  logic want_vco;
  logic on_vco;
  logic busy;
  modport ctl (output want_vco, input on_vco, input busy);
  modport sw (input want_vco, output on_vco, output busy);
endinterface

// [rtl/src_clock_switch.sv]
`timescale 1ns/100ps
`include "pll_ctl_defines.svh"
module src_clock_switch
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sampled source clocks
  input wire logic xtal_in,
  input wire logic vco_in,
  // Selection handshake
  src_switch_if.sw sel,
  // Base clock
  output logic base_out
);
  logic xtal_d_r, vco_d_r, on_vco_r, on_vco_nxt, base_r, base_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  sw_state_type state_r, state_nxt;
  logic x_rise, v_rise, old_rise, new_rise;

  assign x_rise = xtal_in & ~xtal_d_r;
  assign v_rise = vco_in & ~vco_d_r;
  assign old_rise = on_vco_r ? v_rise : x_rise;
  assign new_rise = on_vco_r ? x_rise : v_rise;

  // ---------------------------------------------------------------
  // Transition control
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    on_vco_nxt = on_vco_r;
    base_nxt = base_r;
    case (state_r)
      SW_RUN: begin
        if (sel.want_vco != on_vco_r) begin
          state_nxt = SW_HOLD_OLD; // RL16
          cnt_nxt = 2'h0;
        end else if (old_rise) begin
          base_nxt = ~base_r; // RL17
        end
      end
      // Output frozen until three edges of the old source, then three of the new, have been counted
      SW_HOLD_OLD: begin
        if (old_rise) begin
          if (cnt_r == `SWITCH_WAIT_EDGES - 2'h1) begin
            state_nxt = SW_HOLD_NEW; // RL16
            cnt_nxt = 2'h0;
          end else begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
      end
      SW_HOLD_NEW: begin
        if (new_rise) begin
          if (cnt_r == `SWITCH_WAIT_EDGES - 2'h1) begin
            state_nxt = SW_RUN;
            on_vco_nxt = ~on_vco_r; // RL21
            cnt_nxt = 2'h0;
          end else begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
      end
      default: state_nxt = SW_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xtal_d_r <= 1'b0;
      vco_d_r <= 1'b0;
      state_r <= SW_RUN;
      cnt_r <= 2'h0;
      on_vco_r <= 1'b0;
      base_r <= 1'b0;
    end else begin
      xtal_d_r <= xtal_in;
      vco_d_r <= vco_in;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      on_vco_r <= on_vco_nxt;
      base_r <= base_nxt;
    end
  end

  assign sel.on_vco = on_vco_r;
  assign sel.busy = (state_r != SW_RUN);
  assign base_out = base_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_hold_static;
    @(posedge clk) disable iff (rst) (state_r != SW_RUN) |=> $stable(base_r);
  endproperty
  a_hold_static: assert property (p_hold_static) else $error("base clock moved in hold"); // RL16

  property p_switch_count;
    @(posedge clk) disable iff (rst)
      (state_r == SW_HOLD_OLD) && old_rise && (cnt_r == 2'h2) |=> (state_r == SW_HOLD_NEW);
  endproperty
  a_switch_count: assert property (p_switch_count) else $error("hold did not end"); // RL16

  c_switch_done: cover property (@(posedge clk) disable iff (rst) $changed(on_vco_r));
endmodule

// [rtl/fb_divider.sv]
`timescale 1ns/100ps
module fb_divider
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic vco_in,
  input wire nibble_type divisor,
  // Feedback
  output logic fb_pulse
);
  logic vco_d_r;
  logic fb_r, fb_nxt;
  nibble_type cnt_r, cnt_nxt;

  // ---------------------------------------------------------------
  // Modulo counter on VCO edges
  // ---------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    fb_nxt = 1'b0;
    if (!enable) begin
      cnt_nxt = 4'h0;
    end else if (vco_in && !vco_d_r) begin
      if (cnt_r >= divisor - 4'h1) begin
        cnt_nxt = 4'h0; // RL12
        fb_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vco_d_r <= 1'b0;
      cnt_r <= 4'h0;
      fb_r <= 1'b0;
    end else begin
      vco_d_r <= vco_in;
      cnt_r <= cnt_nxt;
      fb_r <= fb_nxt;
    end
  end

  assign fb_pulse = fb_r;

  property p_no_fb_off;
    @(posedge clk) disable iff (rst) !enable |=> !fb_r;
  endproperty
  a_no_fb_off: assert property (p_no_fb_off) else $error("feedback while off"); // RL15
endmodule

// [verification/pll_mode_and_base_clock_select_tb_top.sv]
`timescale 1ns/100ps
module pll_mode_and_base_clock_select_tb_top;
  import pll_ctl_pkg::*;
  typedef struct {logic [7:0] prog; logic [3:0] n; logic [3:0] l; logic en; int pulses;} row_type;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_d;
  logic crystal, vco, in_trk, out_untrk, in_lock, out_unlock;
  logic loop_en, tracking, fb_pulse, base_out, sel_vco, irq;
  logic [3:0] range_l, divisor;
  logic err_d;
  int fails, total_checks, tg, pl, xcnt, vcnt;
  row_type rows [5];

  pll_clock_ctrl u_dut (.REF_CLK(ref_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CRYSTAL_CLOCK(crystal), .VCO_CLOCK(vco), .IN_TRACK_TOL(in_trk),
    .OUT_UNTRACK_TOL(out_untrk), .IN_LOCK_TOL(in_lock), .OUT_UNLOCK_TOL(out_unlock),
    .LOOP_ENABLE(loop_en), .FILTER_TRACKING(tracking), .VCO_RANGE_FACTOR(range_l),
    .FEEDBACK_DIVISOR(divisor), .FEEDBACK_PULSE(fb_pulse), .BASE_CLOCK_OUT(base_out),
    .BASE_SEL_VCO(sel_vco), .LOOP_IRQ(irq));

  // ---------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Source clocks slower than half the system clock so they can be sampled
  always @(posedge ref_clk) begin
    xcnt <= (xcnt == 7) ? 0 : xcnt + 1;
    vcnt <= (vcnt == 5) ? 0 : vcnt + 1;
    crystal <= (xcnt < 4);
    vco <= (vcnt < 3);
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("Done %s: checks %0d mismatches %0d", name, total_checks, fails);
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0000_00, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      $display("MISMATCH t=%0t bus timeout", $time);
      test_done();
    end else begin
      rd_d = prdata;
      err_d = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Outputs launched at the access edge are looked at once settled
      @(negedge ref_clk);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
    apb(1'b0, addr, 8'h00);
    chk_data(rd_d, {24'h0000_00, exp}, what);
  endtask

  // Toggles of the base clock and feedback pulses over a window
  task automatic measure(input int cycles);
    logic prev;
    tg = 0;
    pl = 0;
    prev = base_out;
    repeat (cycles) begin
      @(posedge ref_clk);
      if (base_out !== prev) tg++;
      if (fb_pulse === 1'b1) pl++;
      prev = base_out;
    end
  endtask

  // Output must stay frozen while the switch waits out both sources
  task automatic switch_to(input logic v);
    logic prev;
    int cyc;
    cyc = 0;
    tg = 0;
    prev = base_out;
    while (sel_vco !== v && cyc < 400) begin
      @(posedge ref_clk);
      cyc++;
      if (cyc > 2 && base_out !== prev) tg++;
      prev = base_out;
    end
    chk_flag(sel_vco, v, "source flip");
    chk_data(32'(tg), 32'h0000_0000, "toggles during hold");
    chk_flag(cyc >= 28, 1'b1, "hold length");
    if (cyc >= 400) begin
      test_done();
    end
  endtask

  task automatic pulse(input logic t, input logic l, input logic u);
    @(posedge ref_clk);
    in_trk <= t;
    in_lock <= l;
    out_unlock <= u;
    out_untrk <= ~t;
    repeat (3) @(posedge ref_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rows = '{'{8'h05, 4'h1, 4'h5, 1'b1, 8}, '{8'h21, 4'h2, 4'h1, 1'b1, 4},
             '{8'h4f, 4'h4, 4'hf, 1'b1, 2}, '{8'h83, 4'h8, 4'h3, 1'b1, 1},
             '{8'h10, 4'h1, 4'h0, 1'b0, 0}};
    fails = 0;
    total_checks = 0;
    xcnt = 0;
    vcnt = 0;
    {reset, psel, penable, pwrite, crystal, vco} = 6'b10_0000;
    {in_trk, out_untrk, in_lock, out_unlock} = 4'b0000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values and mapping
    rd_chk(8'h70, 8'h2f, "ctrl reset");
    rd_chk(8'h74, 8'h00, "bw reset");
    rd_chk(8'h78, 8'h66, "mult reset");
    chk_flag(tracking, 1'b0, "acq at reset");
    rd_chk(8'h7c, 8'h00, "unmapped data");
    chk_flag(err_d, 1'b1, "unmapped error");
    end_test("reset");
    // Multiplier decoding rows
    foreach (rows[i]) begin
      apb(1'b1, 8'h78, rows[i].prog);
      rd_chk(8'h78, rows[i].prog, "mult readback");
      chk_data(32'(divisor), 32'(rows[i].n), "divisor");
      chk_data(32'(range_l), 32'(rows[i].l), "range");
      chk_flag(loop_en, rows[i].en, "loop enable");
      measure(48);
      measure(48);
      chk_data(32'(pl), 32'(rows[i].pulses), "feedback pulses");
    end
    apb(1'b1, 8'h78, 8'h66);
    end_test("multiplier");
    // Manual filter mode
    apb(1'b1, 8'h74, 8'h20);
    chk_flag(tracking, 1'b1, "manual tracking");
    apb(1'b1, 8'h74, 8'h00);
    chk_flag(tracking, 1'b0, "manual acq");
    pulse(1'b1, 1'b1, 1'b0);
    rd_chk(8'h74, 8'h00, "manual no lock");
    apb(1'b1, 8'h70, 8'ha0);
    rd_chk(8'h70, 8'h2f, "manual no ie");
    chk_flag(irq, 1'b0, "manual no irq");
    pulse(1'b0, 1'b0, 1'b0);
    end_test("manual");
    // Loop on and source select protection
    apb(1'b1, 8'h70, 8'h00);
    chk_flag(loop_en, 1'b0, "loop off");
    apb(1'b1, 8'h70, 8'h30);
    rd_chk(8'h70, 8'h2f, "one write sets only on");
    // The measuring window doubles as the acquisition wait
    measure(48);
    chk_data(32'(tg), 32'h0000_0006, "crystal halved");
    apb(1'b1, 8'h74, 8'h20);
    chk_flag(tracking, 1'b1, "tracking before select");
    repeat (16) @(posedge ref_clk);
    apb(1'b1, 8'h70, 8'h30);
    switch_to(1'b1);
    measure(12);
    measure(48);
    chk_data(32'(tg), 32'h0000_0008, "vco halved");
    apb(1'b1, 8'h70, 8'h10);
    rd_chk(8'h70, 8'h3f, "on kept while vco");
    apb(1'b1, 8'h78, 8'h60);
    chk_flag(loop_en, 1'b0, "range zero off");
    rd_chk(8'h70, 8'h2f, "range zero drops select");
    switch_to(1'b0);
    apb(1'b1, 8'h70, 8'h30);
    rd_chk(8'h70, 8'h2f, "select refused");
    apb(1'b1, 8'h78, 8'h66);
    apb(1'b1, 8'h70, 8'h10);
    rd_chk(8'h70, 8'h0f, "loop off beats select");
    end_test("select");
    // Automatic mode, lock and change flag
    apb(1'b1, 8'h74, 8'h80);
    apb(1'b1, 8'h70, 8'ha0);
    pulse(1'b1, 1'b0, 1'b0);
    chk_flag(tracking, 1'b1, "auto tracking");
    apb(1'b1, 8'h74, 8'h80);
    chk_flag(tracking, 1'b1, "acq read only");
    chk_flag(irq, 1'b0, "no toggle no irq");
    pulse(1'b1, 1'b1, 1'b0);
    rd_chk(8'h74, 8'he0, "locked");
    chk_flag(irq, 1'b1, "lock irq");
    rd_chk(8'h70, 8'hef, "flag set");
    chk_flag(irq, 1'b0, "flag cleared by read");
    pulse(1'b0, 1'b0, 1'b1);
    rd_chk(8'h74, 8'h80, "unlocked acq");
    chk_flag(irq, 1'b1, "unlock irq");
    apb(1'b1, 8'h74, 8'h00);
    chk_flag(irq, 1'b0, "manual drops irq");
    rd_chk(8'h70, 8'h2f, "manual masks bits");
    end_test("auto");
    test_done();
  end
endmodule
